// *** include/srs_pkg.sv ***
// Shared constants and types of the supply reset supervisor.
package srs_pkg;
    localparam int unsigned MCLK_PERIOD_PS = 4000;
    localparam int unsigned LINK_PERIOD_PS = 12000;
    localparam int unsigned PS_PER_NS = 1000;
    localparam int unsigned CYC_PER_MS = 1_000_000_000 / MCLK_PERIOD_PS;
    // Reset timeout: typical, least and longest in ms.
    localparam int unsigned RST_TIMEOUT_MS = 200;
    localparam int unsigned RST_TIMEOUT_MIN_MS = 130;
    localparam int unsigned RST_TIMEOUT_MAX_MS = 270;
    localparam int unsigned RST_TIMEOUT_CYC = RST_TIMEOUT_MS * CYC_PER_MS;
    localparam int unsigned POWERUP_TO_ACCESS_MS = 270;
    // Longest programming cycle, rounded down.
    localparam int unsigned PROGRAM_CYCLE_TIME_MS = 5;
    localparam int unsigned PROG_CYC = PROGRAM_CYCLE_TIME_MS * CYC_PER_MS;
    // Longest trip to output delay, rounded down.
    localparam int unsigned TRIP_TO_OUTPUT_DELAY_NS = 5000;
    localparam int unsigned TRIP_DELAY_CYC = TRIP_TO_OUTPUT_DELAY_NS * PS_PER_NS / MCLK_PERIOD_PS;
    // Filter widths, rounded up to whole cycles of their clock.
    localparam int unsigned SUPPLY_TRANSIENT_REJECT_WIDTH_NS = 30;
    localparam int unsigned SUPPLY_REJECT_CYC =
        (SUPPLY_TRANSIENT_REJECT_WIDTH_NS * PS_PER_NS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
    localparam int unsigned MANUAL_GLITCH_NS = 100;
    localparam int unsigned MANUAL_REJECT_CYC =
        (MANUAL_GLITCH_NS * PS_PER_NS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
    localparam int unsigned MANUAL_RESET_MIN_WIDTH_NS = 5000;
    localparam int unsigned INPUT_SPIKE_FILTER_WIDTH_NS = 100;
    localparam int unsigned SPIKE_CYC =
        (INPUT_SPIKE_FILTER_WIDTH_NS * PS_PER_NS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    // Slave address layout: type code in the upper four bits.
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned BYTE_W = 8;
    localparam logic [3:0] DEV_TYPE = 4'hA;
    localparam logic [2:0] DEV_SEL = 3'h0;
    localparam logic [2:0] LAST_BIT = 3'h7;
    typedef enum logic [1:0] {SUP_HOLD, SUP_TIMEOUT, SUP_RUN} srs_sup_st_t;
    typedef enum logic [1:0] {LNK_IDLE, LNK_SHIFT, LNK_ACK_WAIT, LNK_ACK} srs_lnk_st_t;
endpackage : srs_pkg

// *** verilog/srs_sync2.sv ***
// Two flip-flop synchroniser for levels entering a clock domain.
`timescale 1ns/100ps
module srs_sync2 #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= INIT;
            dout <= INIT;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule : srs_sync2

// *** verilog/srs_glitch_filter.sv ***
// Level filter: output follows input only after CYC equal samples in a row.
`timescale 1ns/100ps
module srs_glitch_filter #(
    parameter int unsigned CYC = 8,
    parameter logic INIT = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    localparam int unsigned CW = $clog2(CYC + 1);
    logic [CW-1:0] cnt_r;
    wire differ = din != dout;
    wire settled = cnt_r == CW'(CYC - 1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            dout <= INIT;
        end else begin
            cnt_r <= (differ && !settled) ? cnt_r + CW'(1) : '0;
            dout <= (differ && settled) ? din : dout;
        end
    end
endmodule : srs_glitch_filter

// *** verilog/srs_supervisor.sv ***
// Supply reset supervisor with two-wire slave gating and programming cycle timer.
//
// Notes on behaviour
// - Hold reset until supply good, then timeout.
// - Release open-drain output when timeout ends.
// - Assert reset within 5 us of trip.
// - Ignore supply dips of 30 ns or less.
// - Falling reset pin starts manual reset, active-low build only.
// - Manual reset always lasts full timeout.
// - Reject manual pulses under 100 ns.
// - Memory disabled while reset is active.
// - Reset aborts and refuses bus transactions.
// - No new programming cycle during reset.
// - Running programming cycle survives reset.
// - Program starts at stop, ends within 5 ms.
// - Busy programming: release data, no address ack.
// - Start condition precedes every command.
// - Data change with clock high is start/stop.
// - Filter clock and data spikes to 100 ns.
// - Rising data with clock high is stop.
// - Acknowledge polling write only after cycle ends.
`timescale 1ns/100ps
module srs_supervisor #(
    parameter bit ACTIVE_LOW = 1'b1,
    parameter int unsigned RST_TIMEOUT_CYC = srs_pkg::RST_TIMEOUT_CYC,
    parameter int unsigned PROG_CYC = srs_pkg::PROG_CYC,
    parameter logic [srs_pkg::ADDR_W-1:0] DEV_ADDR = {srs_pkg::DEV_TYPE, srs_pkg::DEV_SEL}
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic bus_clk,
    input wire logic supply_ok,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic mem_enable,
    output logic prog_busy
);
    localparam int unsigned TW = $clog2(RST_TIMEOUT_CYC + 1);
    localparam int unsigned PW = $clog2(PROG_CYC + 1);
    localparam logic DRIVE_LEVEL = ACTIVE_LOW ? 1'b0 : 1'b1;

    // Supervisor domain on mclk.
    srs_pkg::srs_sup_st_t st_r, st_nxt;
    logic [TW-1:0] tmo_cnt_r, tmo_cnt_nxt;
    logic [PW-1:0] prog_cnt_r;
    logic rst_drive_r, prog_busy_r, man_prev_r, req_prev_r;
    logic sup_syn, sup_f, man_syn, man_f, req_syn;
    logic lk_req_tgl_r;

    srs_sync2 #(.W(2), .INIT(2'h1)) u_sync_sup (
        .clk(mclk),
        .rst(rst),
        .din({supply_ok, rst_pin_in}),
        .dout({sup_syn, man_syn})
    );

    srs_glitch_filter #(.CYC(srs_pkg::SUPPLY_REJECT_CYC), .INIT(1'b0)) u_sup_filt (
        .clk(mclk),
        .rst(rst),
        .din(sup_syn),
        .dout(sup_f)
    );

    generate
        if (ACTIVE_LOW) begin : g_manual
            srs_glitch_filter #(.CYC(srs_pkg::MANUAL_REJECT_CYC), .INIT(1'b1)) u_man_filt (
                .clk(mclk),
                .rst(rst),
                .din(man_syn),
                .dout(man_f)
            );
        end else begin : g_no_manual
            assign man_f = 1'b1;
        end
    endgenerate

    // Our own drive pulls the pin low, so edges are only trusted while released.
    // falling edge detect
    wire man_fall = man_prev_r && !man_f && !rst_drive_r;
    wire tmo_done = tmo_cnt_r == TW'(RST_TIMEOUT_CYC - 1);
    wire rst_act_nxt = st_nxt != srs_pkg::SUP_RUN;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            srs_pkg::SUP_HOLD: begin
                if (sup_f) begin
                    st_nxt = srs_pkg::SUP_TIMEOUT;
                end
            end
            srs_pkg::SUP_TIMEOUT: begin
                if (!sup_f) begin
                    st_nxt = srs_pkg::SUP_HOLD;
                end else if (tmo_done) begin
                    st_nxt = srs_pkg::SUP_RUN;
                end
            end
            srs_pkg::SUP_RUN: begin
                if (!sup_f) begin
                    st_nxt = srs_pkg::SUP_HOLD;
                end else if (man_fall) begin
                    st_nxt = srs_pkg::SUP_TIMEOUT;
                end
            end
        endcase
    end

    assign tmo_cnt_nxt = (st_r == srs_pkg::SUP_TIMEOUT && st_nxt == srs_pkg::SUP_TIMEOUT)
        ? tmo_cnt_r + TW'(1) : '0;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= srs_pkg::SUP_HOLD;
            tmo_cnt_r <= '0;
            man_prev_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            tmo_cnt_r <= tmo_cnt_nxt;
            man_prev_r <= man_f;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rst_drive_r <= 1'b1;
            rst_pin_oe_n <= 1'b0;
            rst_pin_out <= DRIVE_LEVEL;
            mem_enable <= 1'b0;
        end else begin
            rst_drive_r <= rst_act_nxt;
            rst_pin_oe_n <= !rst_act_nxt;
            rst_pin_out <= DRIVE_LEVEL;
            mem_enable <= !rst_act_nxt;
        end
    end

    // Programming cycle timer. The stop event arrives as a toggle from the link.
    srs_sync2 #(.W(1), .INIT(1'b0)) u_sync_req (
        .clk(mclk),
        .rst(rst),
        .din(lk_req_tgl_r),
        .dout(req_syn)
    );

    wire prog_req = req_syn ^ req_prev_r;
    wire prog_start = prog_req && !rst_drive_r && !prog_busy_r;
    wire prog_last = prog_cnt_r == PW'(PROG_CYC - 1);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_prev_r <= 1'b0;
            prog_busy_r <= 1'b0;
            prog_cnt_r <= '0;
        end else begin
            req_prev_r <= req_syn;
            prog_busy_r <= prog_start || (prog_busy_r && !prog_last);
            prog_cnt_r <= prog_busy_r && !prog_last ? prog_cnt_r + PW'(1) : '0;
        end
    end

    assign prog_busy = prog_busy_r;

    // Link domain on bus_clk.
    srs_pkg::srs_lnk_st_t lk_st_r, lk_st_nxt;
    logic [srs_pkg::BYTE_W-1:0] sh_r, sh_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic addr_r, addr_nxt, rd_r, rd_nxt, wrote_r, wrote_nxt, oe_n_nxt, tgl_nxt;
    logic lk_rst_s, lk_busy_s, scl_syn, sda_syn, scl_f, sda_f, scl_prev_r, sda_prev_r;

    srs_sync2 #(.W(4), .INIT(4'hF)) u_sync_lnk (
        .clk(bus_clk),
        .rst(rst),
        .din({rst_drive_r, prog_busy_r, scl_in, sda_in}),
        .dout({lk_rst_s, lk_busy_s, scl_syn, sda_syn})
    );

    srs_glitch_filter #(.CYC(srs_pkg::SPIKE_CYC), .INIT(1'b1)) u_scl_filt (
        .clk(bus_clk),
        .rst(rst),
        .din(scl_syn),
        .dout(scl_f)
    );

    srs_glitch_filter #(.CYC(srs_pkg::SPIKE_CYC), .INIT(1'b1)) u_sda_filt (
        .clk(bus_clk),
        .rst(rst),
        .din(sda_syn),
        .dout(sda_f)
    );

    wire scl_rise = scl_f && !scl_prev_r;
    wire scl_fall = !scl_f && scl_prev_r;
    wire scl_held = scl_f && scl_prev_r;
    wire start_det = scl_held && sda_prev_r && !sda_f;
    wire stop_det = scl_held && !sda_prev_r && sda_f;
    wire addr_hit = sh_r[srs_pkg::BYTE_W-1:1] == DEV_ADDR && !lk_busy_s;
    wire ack_ok = addr_r ? addr_hit : !rd_r;

    always_comb begin
        lk_st_nxt = lk_st_r;
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        rd_nxt = rd_r;
        wrote_nxt = wrote_r;
        oe_n_nxt = sda_oe_n;
        tgl_nxt = lk_req_tgl_r;
        if (lk_rst_s) begin
            lk_st_nxt = srs_pkg::LNK_IDLE;
            oe_n_nxt = 1'b1;
            wrote_nxt = 1'b0;
        end else if (start_det) begin
            lk_st_nxt = srs_pkg::LNK_SHIFT;
            cnt_nxt = '0;
            addr_nxt = 1'b1;
            wrote_nxt = 1'b0;
            oe_n_nxt = 1'b1;
        end else if (stop_det) begin
            lk_st_nxt = srs_pkg::LNK_IDLE;
            oe_n_nxt = 1'b1;
            wrote_nxt = 1'b0;
            tgl_nxt = lk_req_tgl_r ^ wrote_r;
        end else begin
            unique case (lk_st_r)
                srs_pkg::LNK_IDLE: begin
                end
                srs_pkg::LNK_SHIFT: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[srs_pkg::BYTE_W-2:0], sda_f};
                        cnt_nxt = cnt_r + 3'h1;
                        if (cnt_r == srs_pkg::LAST_BIT) begin
                            lk_st_nxt = srs_pkg::LNK_ACK_WAIT;
                        end
                    end
                end
                srs_pkg::LNK_ACK_WAIT: begin
                    if (scl_fall) begin
                        oe_n_nxt = !ack_ok;
                        lk_st_nxt = ack_ok ? srs_pkg::LNK_ACK : srs_pkg::LNK_IDLE;
                        rd_nxt = addr_r ? sh_r[0] : rd_r;
                        wrote_nxt = wrote_r || (ack_ok && !addr_r);
                    end
                end
                srs_pkg::LNK_ACK: begin
                    if (scl_fall) begin
                        oe_n_nxt = 1'b1;
                        addr_nxt = 1'b0;
                        cnt_nxt = '0;
                        lk_st_nxt = rd_r ? srs_pkg::LNK_IDLE : srs_pkg::LNK_SHIFT;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge bus_clk or posedge rst) begin
        if (rst) begin
            lk_st_r <= srs_pkg::LNK_IDLE;
            sh_r <= '0;
            cnt_r <= '0;
            {addr_r, rd_r, wrote_r, lk_req_tgl_r} <= 4'h0;
            {scl_prev_r, sda_prev_r, sda_oe_n} <= 3'h7;
            sda_out <= 1'b0;
        end else begin
            lk_st_r <= lk_st_nxt;
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            {addr_r, rd_r, wrote_r, lk_req_tgl_r} <= {addr_nxt, rd_nxt, wrote_nxt, tgl_nxt};
            {scl_prev_r, sda_prev_r, sda_oe_n} <= {scl_f, sda_f, oe_n_nxt};
            sda_out <= 1'b0;
        end
    end

    // Checks on the supervisor domain.
    AST_TRIP_DELAY: assert property (
        @(posedge mclk) disable iff (rst) (!sup_syn) [*8] |-> ##[0:2] rst_drive_r)
        else $error("reset not asserted after supply trip");
    AST_DIP_IGNORED: assert property (
        @(posedge mclk) disable iff (rst)
        (st_r == srs_pkg::SUP_RUN && sup_syn && man_f) ##1 (!sup_syn) [*7] ##1 sup_syn
        |-> !rst_drive_r [*4])
        else $error("short supply dip caused a reset");
    AST_TIMEOUT_LEN: assert property (
        @(posedge mclk) disable iff (rst)
        $fell(rst_drive_r) |-> $past(tmo_cnt_r) == TW'(RST_TIMEOUT_CYC - 1))
        else $error("reset released before full timeout");
    AST_RELEASE: assert property (
        @(posedge mclk) disable iff (rst)
        st_r == srs_pkg::SUP_RUN |-> rst_pin_oe_n && mem_enable)
        else $error("output still driven after timeout");
    AST_MANUAL: assert property (
        @(posedge mclk) disable iff (rst) man_fall |=> rst_drive_r [*8] ##1 tmo_cnt_r != '0)
        else $error("manual reset did not start timeout");
    AST_MAN_REJECT: assert property (
        @(posedge mclk) disable iff (rst)
        (st_r == srs_pkg::SUP_RUN && man_syn && sup_f) ##1 (!man_syn) [*4] ##1 man_syn
        |-> !rst_drive_r [*8])
        else $error("short manual pulse caused a reset");
    AST_MEM_GATE: assert property (
        @(posedge mclk) disable iff (rst) rst_drive_r |-> !mem_enable)
        else $error("memory enabled during reset");
    AST_NO_LAUNCH: assert property (
        @(posedge mclk) disable iff (rst) $rose(prog_busy_r) |-> !$past(rst_drive_r))
        else $error("programming launched during reset");
    AST_PROG_RUNS: assert property (
        @(posedge mclk) disable iff (rst)
        prog_busy_r && prog_cnt_r < PW'(PROG_CYC - 1) |=> prog_busy_r)
        else $error("programming cycle cut short");
    AST_PROG_END: assert property (
        @(posedge mclk) disable iff (rst) prog_busy_r && prog_last |=> !prog_busy_r)
        else $error("programming cycle overran");

    // Checks on the link domain.
    AST_ABORT: assert property (
        @(posedge bus_clk) disable iff (rst)
        lk_rst_s |=> lk_st_r == srs_pkg::LNK_IDLE && sda_oe_n)
        else $error("transaction survived reset");
    AST_BUSY_NACK: assert property (
        @(posedge bus_clk) disable iff (rst)
        lk_busy_s && lk_st_r != srs_pkg::LNK_ACK && addr_r |=> sda_oe_n)
        else $error("address acknowledged while programming");
    AST_WAIT_START: assert property (
        @(posedge bus_clk) disable iff (rst)
        lk_st_r == srs_pkg::LNK_IDLE && !start_det |=> lk_st_r == srs_pkg::LNK_IDLE)
        else $error("bus left idle without start");

    COV_POWER_UP: cover property (@(posedge mclk) disable iff (rst) $fell(rst_drive_r));
    COV_MANUAL: cover property (@(posedge mclk) disable iff (rst) man_fall);
    COV_PROG: cover property (@(posedge mclk) disable iff (rst) prog_start);
    COV_ACK: cover property (@(posedge bus_clk) disable iff (rst) $fell(sda_oe_n));
endmodule : srs_supervisor

// *** tb/srs_host_model.sv ***
// Two-wire bus master model standing on the far side of the supervisor.
`timescale 1ns/100ps
module srs_host_model #(
    parameter int unsigned QTR = 63
) (
    input wire logic mclk,
    input wire logic sda_wire,
    output logic scl_oe_n,
    output logic sda_oe_n,
    output logic ack_evt,
    output logic ack_bit
);
    initial begin
        scl_oe_n = 1'b1;
        sda_oe_n = 1'b1;
        ack_evt = 1'b0;
        ack_bit = 1'b1;
    end
    task automatic wait_q(input int k);
        repeat (k * QTR) @(negedge mclk);
    endtask : wait_q
    task automatic bus_start();
        wait_q(6);
        sda_oe_n = 1'b0;
        wait_q(1);
        scl_oe_n = 1'b0;
        wait_q(1);
    endtask : bus_start
    task automatic bus_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda_oe_n = b[i];
            wait_q(1);
            scl_oe_n = 1'b1;
            wait_q(1);
            scl_oe_n = 1'b0;
            wait_q(1);
        end
        sda_oe_n = 1'b1;
        wait_q(1);
        scl_oe_n = 1'b1;
        wait_q(1);
        ack_bit = sda_wire;
        ack_evt = 1'b1;
        scl_oe_n = 1'b0;
        @(negedge mclk);
        ack_evt = 1'b0;
        wait_q(1);
    endtask : bus_byte
    task automatic bus_stop();
        sda_oe_n = 1'b0;
        wait_q(1);
        scl_oe_n = 1'b1;
        wait_q(1);
        sda_oe_n = 1'b1;
        wait_q(1);
    endtask : bus_stop
endmodule : srs_host_model

// *** tb/test_supply_reset_supervisor.sv ***
// Self-checking bench of the supply reset supervisor with a bus master model.
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("Error %0t: %s", $time, msg); \
    end \
end
module test_supply_reset_supervisor;
    localparam int unsigned TMO = 2000;
    localparam int unsigned PRG = 5000;
    localparam int unsigned MR_HOLD = 1250;
    localparam int LIMIT = 90000;
    logic mclk = 1'b0;
    logic bus_clk = 1'b0;
    logic rst = 1'b1;
    logic supply_ok = 1'b0;
    logic mr_drv_n = 1'b1;
    logic rst_pin_wire, rst_pin_out, rst_pin_oe_n, scl_wire, sda_wire, sda_out, sda_oe_n;
    logic mem_enable, prog_busy, h_scl_oe_n, h_sda_oe_n, ack_evt, ack_bit, exp_a;
    logic exp_q[$];
    logic [31:0] rng = 32'h0000004A;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    int n2;
    int t0;
    logic spk_n = 1'b1;
    logic busy_q = 1'b0;
    always #2 mclk = ~mclk;
    initial begin
        #1.3;
        forever #6 bus_clk = ~bus_clk;
    end
    // Every pin has a pull-up; each party only ever pulls low.
    assign rst_pin_wire = mr_drv_n & (rst_pin_oe_n | rst_pin_out);
    // A short low spike on the clock wire models noise that the input filter must absorb.
    assign scl_wire = h_scl_oe_n & spk_n;
    assign sda_wire = h_sda_oe_n & (sda_oe_n | sda_out);
    srs_supervisor #(.ACTIVE_LOW(1'b1), .RST_TIMEOUT_CYC(TMO), .PROG_CYC(PRG)) dut (
        .mclk(mclk), .rst(rst), .bus_clk(bus_clk), .supply_ok(supply_ok),
        .rst_pin_in(rst_pin_wire), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
        .scl_in(scl_wire), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .mem_enable(mem_enable), .prog_busy(prog_busy)
    );
    srs_host_model host (
        .mclk(mclk), .sda_wire(sda_wire), .scl_oe_n(h_scl_oe_n), .sda_oe_n(h_sda_oe_n),
        .ack_evt(ack_evt), .ack_bit(ack_bit)
    );
    function automatic logic [7:0] next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction : next_rand
    task automatic wait_lvl(input logic sel, input logic lvl, input int lim, output int k);
        k = 0;
        while ((sel ? prog_busy : rst_pin_oe_n) !== lvl && k < lim) begin
            @(negedge mclk);
            k++;
        end
    endtask : wait_lvl
    task automatic power_up();
        @(negedge mclk);
        supply_ok = 1'b1;
        wait_lvl(1'b0, 1'b1, TMO + 40, n);
        @(negedge mclk);
        `CHK(n >= TMO && n <= TMO + 14, 1'b1, "release time after supply good")
        `CHK(rst_pin_wire && mem_enable, 1'b1, "pin released and memory enabled")
        // Let the pin filter settle on the released level, or a following pulse goes unseen.
        repeat (40) @(negedge mclk);
    endtask : power_up
    task automatic trip();
        @(negedge mclk);
        supply_ok = 1'b0;
        wait_lvl(1'b0, 1'b0, 40, n);
        @(negedge mclk);
        `CHK(n <= 12 && mem_enable === 1'b0, 1'b1, "trip to reset delay")
        `CHK(rst_pin_wire, 1'b0, "pin driven to its active level")
    endtask : trip
    task automatic frame(input logic [7:0] adr, input logic a_exp, input int nd, input logic d_exp);
        host.bus_start();
        exp_q.push_back(a_exp);
        host.bus_byte(adr);
        for (int i = 0; i < nd; i++) begin
            exp_q.push_back(d_exp);
            host.bus_byte(next_rand());
        end
        host.bus_stop();
    endtask : frame
    initial begin
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        `CHK({rst_pin_oe_n, mem_enable, prog_busy, sda_oe_n}, 4'h1, "levels in reset")
        rst = 1'b0;
        repeat (50) @(negedge mclk);
        `CHK(rst_pin_oe_n, 1'b0, "held while supply low")
        power_up();
        supply_ok = 1'b0;
        repeat (7) @(negedge mclk);
        supply_ok = 1'b1;
        repeat (30) @(negedge mclk);
        `CHK(rst_pin_oe_n, 1'b1, "short supply dip ignored")
        trip();
        repeat (10) @(negedge mclk);
        power_up();
        mr_drv_n = 1'b0;
        repeat (4) @(negedge mclk);
        mr_drv_n = 1'b1;
        repeat (40) @(negedge mclk);
        mr_drv_n = 1'b0;
        repeat (20) @(negedge mclk);
        mr_drv_n = 1'b1;
        repeat (40) @(negedge mclk);
        `CHK(rst_pin_oe_n, 1'b1, "short manual pulse ignored")
        mr_drv_n = 1'b0;
        wait_lvl(1'b0, 1'b0, 40, n);
        `CHK(n <= 28, 1'b1, "manual edge recognised")
        repeat (MR_HOLD - n) @(negedge mclk);
        mr_drv_n = 1'b1;
        wait_lvl(1'b0, 1'b1, TMO, n2);
        `CHK(MR_HOLD - n + n2 >= TMO && MR_HOLD - n + n2 <= TMO + 4, 1'b1, "manual length")
        frame(8'hA2, 1'b1, 0, 1'b0);
        frame(8'hA1, 1'b0, 0, 1'b0);
        frame(8'hA0, 1'b0, 2, 1'b0);
        wait_lvl(1'b1, 1'b1, 100, n);
        `CHK(prog_busy, 1'b1, "programming starts after stop")
        frame(8'hA0, 1'b1, 0, 1'b0);
        wait_lvl(1'b1, 1'b0, PRG, n);
        `CHK(cyc - t0 >= PRG - 1 && cyc - t0 <= PRG + 1, 1'b1, "programming length")
        fork
            frame(8'hA0, 1'b0, 0, 1'b0);
            begin
                repeat (9 * 63 + 20) @(negedge mclk);
                spk_n = 1'b0;
                repeat (next_rand() % 20 + 1) @(negedge mclk);
                spk_n = 1'b1;
            end
        join
        repeat (200) @(negedge mclk);
        `CHK(prog_busy, 1'b0, "stop without data does not program")
        frame(8'hA0, 1'b0, 1, 1'b0);
        wait_lvl(1'b1, 1'b1, 100, n);
        trip();
        frame(8'hA0, 1'b1, 1, 1'b1);
        `CHK(prog_busy, 1'b1, "programming survives reset")
        wait_lvl(1'b1, 1'b0, PRG, n);
        `CHK(cyc - t0 >= PRG - 1 && cyc - t0 <= PRG + 1, 1'b1, "length in reset")
        power_up();
        host.bus_start();
        exp_q.push_back(1'b0);
        host.bus_byte(8'hA0);
        trip();
        exp_q.push_back(1'b1);
        host.bus_byte(next_rand());
        host.bus_stop();
        repeat (200) @(negedge mclk);
        `CHK(prog_busy, 1'b0, "no programming after aborted write")
        power_up();
        `CHK(exp_q.size() == 0, 1'b1, "every acknowledge slot seen")
        wrap_up();
    end
    // The start of each programming cycle is stamped where it first shows, not after a frame.
    always @(negedge mclk) begin
        busy_q <= prog_busy;
        if (prog_busy === 1'b1 && busy_q !== 1'b1) begin
            t0 <= cyc;
        end
    end
    always @(posedge ack_evt) begin
        exp_a = (exp_q.size() > 0) ? exp_q.pop_front() : 1'bx;
        `CHK(ack_bit, exp_a, "acknowledge slot level")
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            $display("Error %0t: run limit reached", $time);
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
endmodule : test_supply_reset_supervisor
